//--- nvp_pkg.sv
// Shared constants, types and state record of the nonvolatile program and erase controller.
package nvp_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [15:0] IDX_CONTROL = 16'h0760;
    localparam logic [15:0] IDX_ADDR_LO = 16'h0762;
    localparam logic [15:0] IDX_ADDR_HI = 16'h0764;
    localparam logic [15:0] IDX_KEY     = 16'h0766;
    localparam logic [15:0] IDX_STATUS  = 16'h0768;

    // Control register field positions.
    localparam int CTL_GO_BIT    = 15;
    localparam int CTL_WRITE_ENABLE_BIT_BIT  = 14;
    localparam int CTL_FAULT_BIT = 13;
    localparam int CTL_TIMED_BIT = 8;
    localparam int CTL_OP_MSB    = 6;

    // Status register field positions.
    localparam int STS_DONE_BIT  = 0;
    localparam int STS_BUSY_BIT  = 1;
    localparam int STS_STALL_BIT = 2;

    // Unlock key values.
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // Operation codes held in the operation select field.
    localparam logic [6:0] OP_FLASH_ROW_ERASE = 7'h41;
    localparam logic [6:0] OP_FLASH_ROW_PROG  = 7'h01;
    localparam logic [6:0] OP_EE_BLOCK_ERASE  = 7'h45;
    localparam logic [6:0] OP_EE_WORD_ERASE   = 7'h44;
    localparam logic [6:0] OP_EE_BLOCK_PROG   = 7'h05;
    localparam logic [6:0] OP_EE_WORD_PROG    = 7'h04;
    localparam int OP_ERASE_BIT  = 6;
    localparam int OP_EEPROM_BIT = 2;
    localparam int OP_MULTI_BIT  = 0;

    // Memory geometry.
    localparam int          ROW_WORDS    = 32;
    localparam int          LATCH_W      = 24;
    localparam logic [23:0] EE_FIRST     = 24'h7FFC00;
    localparam logic [23:0] EE_LAST      = 24'h7FFFFE;
    localparam logic [23:0] ROW_MASK     = 24'hFFFFC0;
    localparam logic [23:0] EE_BLK_MASK  = 24'hFFFFE0;
    localparam logic [23:0] WORD_MASK    = 24'hFFFFFE;
    localparam logic [15:0] EE_BUSY_READ = 16'hFFFF;

    // Cycle timing.
    localparam int WRITE_TIME_US = 2000;
    localparam int CLK_MHZ       = 10;
    localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;

    ////////////////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {TBL_NONE, TBL_WRITE_LOW, TBL_WRITE_HIGH, TBL_READ_LOW} nvp_tbl_op_t;
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} nvp_key_t;

    typedef struct packed {
        nvp_tbl_op_t op;
        logic [23:0] addr;
        logic [15:0] wdata;
    } nvp_tbl_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] rdata;
    } nvp_tbl_rsp_t;

    typedef struct packed {
        logic        start;
        logic        erase;
        logic        eeprom;
        logic        multi;
        logic [23:0] addr;
    } nvp_arr_cmd_t;

    typedef struct packed {
        logic                                 go;
        logic                                 write_enable_bit;
        logic                                 fault;
        logic                                 timed;
        logic [6:0]                           op;
        logic [15:0]                          adr_lo;
        logic [7:0]                           adr_hi;
        nvp_key_t                             key;
        logic [23:0]                          timer;
        logic                                 done;
        nvp_arr_cmd_t                         cmd;
        nvp_tbl_rsp_t                         rsp;
        logic [LATCH_W-1:0]                   lat_data;
        logic [31:0]                          prdata;
        logic                                 pslverr;
        logic [ROW_WORDS-1:0][LATCH_W-1:0]    latch;
    } nvp_state_t;

endpackage : nvp_pkg

//--- nvp_ctrl.sv
// Program flash and data EEPROM program and erase controller with an APB register slave.
//
// How it works
// - Program flash is erased and programmed one 32-word row at a time.
// - A cycle starts only after key 0x55, then 0xAA, then setting go.
// - The processor is stalled while a program flash cycle runs.
// - The go bit clears itself when the cycle completes.
// - Ninety-six bytes of row latches are filled by low and high table writes.
// - A high table write stores only the low byte of its operand.
// - Control value 0x4041 selects a program flash row erase with writes enabled.
// - Control value 0x4045 selects a data EEPROM block erase with writes enabled.
// - Data EEPROM holds 512 words from 0x7FFC00 to 0x7FFFFE.
// - Data EEPROM supports single-word and 16-word block operations.
// - EEPROM cycles do not stall the processor.
// - EEPROM reads during an EEPROM cycle return 0xFFFF.
// - Software can set the go bit but never clear it.
// - The write enable bit permits writes and is zero after power-up.
// - A master clear or watchdog reset during a write sets the fault bit.
// - The low address register survives such a reset.
// - Completion sets the done flag, which only software or a master clear or watchdog reset clears.
// - A low table read returns the word at the current program address.
// - A write starts only if key writes and go come in exact order.
// - Go cannot be set unless write enable was set by an earlier write.
// - Hardware clears write enable only on a master clear or watchdog reset; clearing it does not stop a cycle.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module nvp_ctrl #(
    parameter int WRITE_CYCLES = nvp_pkg::WRITE_CYCLES
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        master_clear_pin_rst,
    input  wire logic                        watchdog_timer_rst,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [15:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic                             pready,
    output logic [31:0]                      prdata,
    output logic                             pslverr,
    input  wire nvp_pkg::nvp_tbl_req_t       tbl_req,
    output nvp_pkg::nvp_tbl_rsp_t            tbl_rsp,
    output logic [23:0]                      arr_rd_addr,
    input  wire logic [15:0]                 arr_rd_data,
    output nvp_pkg::nvp_arr_cmd_t            arr_cmd,
    input  wire logic [4:0]                  arr_latch_idx,
    output logic [nvp_pkg::LATCH_W-1:0]      arr_latch_data,
    output logic                             cpu_stall,
    output logic                             nvm_done_flag
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    function automatic logic reg_hit(input logic [15:0] a, input logic [15:0] idx);
        reg_hit = (a == {idx[13:0], 2'b00});
    endfunction : reg_hit

    function automatic logic op_legal(input logic [6:0] op);
        op_legal = (op == nvp_pkg::OP_FLASH_ROW_ERASE) || (op == nvp_pkg::OP_FLASH_ROW_PROG)
                || (op == nvp_pkg::OP_EE_BLOCK_ERASE) || (op == nvp_pkg::OP_EE_WORD_ERASE)
                || (op == nvp_pkg::OP_EE_BLOCK_PROG) || (op == nvp_pkg::OP_EE_WORD_PROG);
    endfunction : op_legal

    function automatic logic in_eeprom(input logic [23:0] a);
        in_eeprom = (a >= nvp_pkg::EE_FIRST) && (a <= nvp_pkg::EE_LAST);
    endfunction : in_eeprom

    function automatic logic [23:0] align(input logic [6:0] op, input logic [23:0] a);
        if (!op[nvp_pkg::OP_EEPROM_BIT]) begin
            align = a & nvp_pkg::ROW_MASK;
        end else if (op[nvp_pkg::OP_MULTI_BIT]) begin
            align = a & nvp_pkg::EE_BLK_MASK;
        end else begin
            align = a & nvp_pkg::WORD_MASK;
        end
    endfunction : align

    ////////////////////////////////////////////////////////////////////////////////////////////
    // State and access qualifiers.

    localparam logic [23:0] CYCLE_LAST = 24'(WRITE_CYCLES - 1);

    nvp_pkg::nvp_state_t s_q;
    nvp_pkg::nvp_state_t s_d;

    logic        setup;
    logic        access;
    logic        bus_wr;
    logic        hit_ctl;
    logic        hit_lo;
    logic        hit_hi;
    logic        hit_key;
    logic        hit_sts;
    logic        hit_any;
    logic [4:0]  tbl_idx;
    logic [6:0]  new_op;
    logic        key_wr;
    logic        go_req;

    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign bus_wr  = access && pwrite;
    assign hit_ctl = reg_hit(paddr, nvp_pkg::IDX_CONTROL);
    assign hit_lo  = reg_hit(paddr, nvp_pkg::IDX_ADDR_LO);
    assign hit_hi  = reg_hit(paddr, nvp_pkg::IDX_ADDR_HI);
    assign hit_key = reg_hit(paddr, nvp_pkg::IDX_KEY);
    assign hit_sts = reg_hit(paddr, nvp_pkg::IDX_STATUS);
    assign hit_any = hit_ctl || hit_lo || hit_hi || hit_key || hit_sts;
    assign tbl_idx = tbl_req.addr[5:1];
    assign new_op  = pwdata[nvp_pkg::CTL_OP_MSB:0];
    assign key_wr  = bus_wr && hit_key;

    assign go_req  = bus_wr && hit_ctl && pwdata[nvp_pkg::CTL_GO_BIT] && !s_q.go
                  && s_q.write_enable_bit && (s_q.key == nvp_pkg::KEY_ARMED) && op_legal(new_op);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        s_d = s_q;
        s_d.cmd.start = 1'b0;
        s_d.rsp.valid = 1'b0;
        s_d.lat_data  = s_q.latch[arr_latch_idx];

        // disarm on any other bus access, to any register
        if (access) begin
            unique case (s_q.key)
                nvp_pkg::KEY_IDLE: begin
                    s_d.key = (key_wr && pwdata[7:0] == nvp_pkg::KEY_FIRST)
                            ? nvp_pkg::KEY_GOT_FIRST : nvp_pkg::KEY_IDLE;
                end
                nvp_pkg::KEY_GOT_FIRST: begin
                    if (key_wr && pwdata[7:0] == nvp_pkg::KEY_SECOND) begin
                        s_d.key = nvp_pkg::KEY_ARMED;
                    end else if (key_wr && pwdata[7:0] == nvp_pkg::KEY_FIRST) begin
                        s_d.key = nvp_pkg::KEY_GOT_FIRST;
                    end else begin
                        s_d.key = nvp_pkg::KEY_IDLE;
                    end
                end
                nvp_pkg::KEY_ARMED: begin
                    s_d.key = nvp_pkg::KEY_IDLE;
                end
                default: begin
                    s_d.key = nvp_pkg::KEY_IDLE;
                end
            endcase
        end

        // Control register write.
        if (bus_wr && hit_ctl) begin
            // write enable changes only by software or by a master clear or watchdog reset
            s_d.write_enable_bit  = pwdata[nvp_pkg::CTL_WRITE_ENABLE_BIT_BIT];
            s_d.fault = s_q.fault && pwdata[nvp_pkg::CTL_FAULT_BIT];
            if (!s_q.go) begin
                s_d.op    = new_op;
                s_d.timed = pwdata[nvp_pkg::CTL_TIMED_BIT];
            end
        end

        if (go_req) begin
            s_d.go          = 1'b1;
            s_d.timer       = CYCLE_LAST;
            s_d.cmd.start   = 1'b1;
            s_d.cmd.erase   = new_op[nvp_pkg::OP_ERASE_BIT];
            s_d.cmd.eeprom  = new_op[nvp_pkg::OP_EEPROM_BIT];
            s_d.cmd.multi   = new_op[nvp_pkg::OP_MULTI_BIT];
            s_d.cmd.addr    = align(new_op, {s_q.adr_hi, s_q.adr_lo});
        end

        if (bus_wr && hit_lo) begin
            s_d.adr_lo = pwdata[15:0];
        end
        if (bus_wr && hit_hi) begin
            s_d.adr_hi = pwdata[7:0];
        end

        if (bus_wr && hit_sts && pwdata[nvp_pkg::STS_DONE_BIT]) begin
            s_d.done = 1'b0;
        end

        if (s_q.go) begin
            if (s_q.timer == '0) begin
                s_d.go   = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.timer = s_q.timer - 24'h000001;
            end
        end

        // Table accesses; the address of the last one is captured.
        if (tbl_req.op != nvp_pkg::TBL_NONE) begin
            s_d.adr_lo = tbl_req.addr[15:0];
            s_d.adr_hi = tbl_req.addr[23:16];
        end
        unique case (tbl_req.op)
            nvp_pkg::TBL_WRITE_LOW: begin
                s_d.latch[tbl_idx][15:0] = tbl_req.wdata;
            end
            nvp_pkg::TBL_WRITE_HIGH: begin
                s_d.latch[tbl_idx][23:16] = tbl_req.wdata[7:0];
            end
            nvp_pkg::TBL_READ_LOW: begin
                s_d.rsp.valid = 1'b1;
                if (s_q.go && s_q.cmd.eeprom && in_eeprom(tbl_req.addr)) begin
                    s_d.rsp.rdata = nvp_pkg::EE_BUSY_READ;
                end else begin
                    s_d.rsp.rdata = arr_rd_data;
                end
            end
            nvp_pkg::TBL_NONE: begin
            end
        endcase

        // Bus read data is captured in the setup cycle.
        if (setup) begin
            s_d.pslverr = !hit_any;
            s_d.prdata  = '0;
            if (!pwrite && hit_ctl) begin
                s_d.prdata[nvp_pkg::CTL_GO_BIT]        = s_q.go;
                s_d.prdata[nvp_pkg::CTL_WRITE_ENABLE_BIT_BIT]      = s_q.write_enable_bit;
                s_d.prdata[nvp_pkg::CTL_FAULT_BIT]     = s_q.fault;
                s_d.prdata[nvp_pkg::CTL_TIMED_BIT]     = s_q.timed;
                s_d.prdata[nvp_pkg::CTL_OP_MSB:0]      = s_q.op;
            end else if (!pwrite && hit_lo) begin
                s_d.prdata[15:0] = s_q.adr_lo;
            end else if (!pwrite && hit_hi) begin
                s_d.prdata[7:0] = s_q.adr_hi;
            end else if (!pwrite && hit_sts) begin
                s_d.prdata[nvp_pkg::STS_DONE_BIT]  = s_q.done;
                s_d.prdata[nvp_pkg::STS_BUSY_BIT]  = s_q.go;
                s_d.prdata[nvp_pkg::STS_STALL_BIT] = s_q.go && !s_q.cmd.eeprom;
            end
        end

        if (master_clear_pin_rst || watchdog_timer_rst) begin
            s_d        = '0;
            s_d.fault  = s_q.go;
            s_d.adr_lo = s_q.adr_lo;
            s_d.adr_hi = s_q.adr_hi;
            s_d.latch  = s_q.latch;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign pready         = access;
    assign prdata         = s_q.prdata;
    assign pslverr        = access && s_q.pslverr;
    assign tbl_rsp        = s_q.rsp;
    assign arr_rd_addr    = tbl_req.addr;
    assign arr_cmd        = s_q.cmd;
    assign arr_latch_data = s_q.lat_data;
    assign cpu_stall      = s_q.go && !s_q.cmd.eeprom;
    assign nvm_done_flag  = s_q.done;

endmodule : nvp_ctrl

`default_nettype wire

//--- nvp_ctrl_asserts.sv
// Port checks of the program and erase controller.
`timescale 1ns/1ns
`default_nettype none
module nvp_ctrl_asserts #(
    parameter int WRITE_CYCLES = 8
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  master_clear_pin_rst,
    input wire logic                  watchdog_timer_rst,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [15:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire nvp_pkg::nvp_tbl_req_t tbl_req,
    input wire nvp_pkg::nvp_tbl_rsp_t tbl_rsp,
    input wire nvp_pkg::nvp_arr_cmd_t arr_cmd,
    input wire logic                  cpu_stall,
    input wire logic                  nvm_done_flag
);
    logic [1:0]  arm_q;
    logic [15:0] cnt_q;
    logic        srst_q;
    wire wr = psel && penable && pwrite;
    wire srst = master_clear_pin_rst || watchdog_timer_rst;
    wire key_wr = wr && paddr == (nvp_pkg::IDX_KEY << 2);
    wire go_ok = wr && arm_q == 2'h2 && pwdata[15] && paddr == (nvp_pkg::IDX_CONTROL << 2);
    wire clr_wr = wr && pwdata[0] && paddr == (nvp_pkg::IDX_STATUS << 2);
    ////////////////////////////////////////////////////////////////////////////////
    // Unlock progress and stall length as seen at the ports.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_q <= 2'h0;
            cnt_q <= 16'h0000;
            srst_q <= 1'b0;
        end else begin
            srst_q <= srst;
            cnt_q <= (cpu_stall && !srst) ? cnt_q + 16'h0001 : 16'h0000;
            if (srst || (psel && penable && !key_wr)) begin
                arm_q <= 2'h0;
            end else if (key_wr) begin
                arm_q <= pwdata[7:0] == nvp_pkg::KEY_FIRST ? 2'h1 :
                    (arm_q == 2'h1 && pwdata[7:0] == nvp_pkg::KEY_SECOND) ? 2'h2 : 2'h0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || srst || srst_q);
    sequence s_flash_start;
        arr_cmd.start && !arr_cmd.eeprom;
    endsequence
    sequence s_stalled;
        cpu_stall ##1 cpu_stall;
    endsequence
    property p_unlock; arr_cmd.start |-> $past(go_ok); endproperty
    a_unlock: assert property (p_unlock) else $error("start without unlock");
    property p_stall; s_flash_start |-> s_stalled; endproperty
    a_stall: assert property (p_stall) else $error("flash cycle not stalling");
    property p_ee_free; cpu_stall |-> !arr_cmd.eeprom; endproperty
    a_ee_free: assert property (p_ee_free) else $error("eeprom cycle stalls");
    property p_stall_max; cpu_stall |-> cnt_q < WRITE_CYCLES; endproperty
    a_stall_max: assert property (p_stall_max) else $error("cycle too long");
    property p_stall_end; $fell(cpu_stall) |-> cnt_q == 16'(WRITE_CYCLES) && nvm_done_flag; endproperty
    a_stall_end: assert property (p_stall_end) else $error("bad cycle end");
    property p_done_hold; nvm_done_flag && !clr_wr |=> nvm_done_flag; endproperty
    a_done_hold: assert property (p_done_hold) else $error("done lost");
    property p_row; s_flash_start |-> arr_cmd.addr[5:0] == 6'h00; endproperty
    a_row: assert property (p_row) else $error("row not aligned");
    property p_blk; arr_cmd.start && arr_cmd.eeprom && arr_cmd.multi |-> arr_cmd.addr[4:0] == 5'h00; endproperty
    a_blk: assert property (p_blk) else $error("block not aligned");
    property p_rsp; tbl_req.op == nvp_pkg::TBL_READ_LOW |=> tbl_rsp.valid; endproperty
    a_rsp: assert property (p_rsp) else $error("no read answer");
endmodule : nvp_ctrl_asserts
bind nvp_ctrl nvp_ctrl_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) nvp_ctrl_asserts_i (.pclk, .presetn,
    .master_clear_pin_rst, .watchdog_timer_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .tbl_req, .tbl_rsp, .arr_cmd, .cpu_stall, .nvm_done_flag);
`default_nettype wire

//--- nvp_array_model.sv
// Behavioural model of the nonvolatile array facing the controller.
`timescale 1ns/1ns
`default_nettype none
module nvp_array_model (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [23:0]           arr_rd_addr,
    output logic [15:0]                arr_rd_data,
    input  wire nvp_pkg::nvp_arr_cmd_t arr_cmd,
    output logic [4:0]                 arr_latch_idx,
    input  wire logic [23:0]           arr_latch_data
);
    logic [23:0]           img [32];
    nvp_pkg::nvp_arr_cmd_t last_cmd;
    int                    starts;
    assign arr_rd_data = arr_rd_addr[15:0] ^ 16'h5A5A;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arr_latch_idx <= 5'h00;
            starts <= 0;
        end else begin
            arr_latch_idx <= arr_latch_idx + 5'h01;
            img[arr_latch_idx - 5'h01] <= arr_latch_data;
            if (arr_cmd.start) begin
                starts <= starts + 1;
                last_cmd <= arr_cmd;
            end
        end
    end
endmodule : nvp_array_model
`default_nettype wire

//--- nvp_ctrl_tb.sv
// Self-checking bench for the program and erase controller.
`timescale 1ns/1ns
`default_nettype none
module nvp_ctrl_tb;
    localparam logic [15:0] A_CTL = nvp_pkg::IDX_CONTROL << 2;
    localparam logic [15:0] A_ADL = nvp_pkg::IDX_ADDR_LO << 2;
    localparam logic [15:0] A_ADH = nvp_pkg::IDX_ADDR_HI << 2;
    localparam logic [15:0] A_KEY = nvp_pkg::IDX_KEY << 2;
    localparam logic [15:0] A_STS = nvp_pkg::IDX_STATUS << 2;
    logic pclk, pready, pslverr, cpu_stall, nvm_done_flag, er;
    logic presetn = 0, master_clear_pin_rst = 0, watchdog_timer_rst = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = '0, arr_rd_data;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [23:0] arr_rd_addr, arr_latch_data, ad, msk;
    logic [4:0] arr_latch_idx;
    logic [6:0] op;
    logic [6:0] ops [6] = '{7'h41, 7'h01, 7'h45, 7'h44, 7'h05, 7'h04};
    nvp_pkg::nvp_tbl_req_t tbl_req = '0;
    nvp_pkg::nvp_tbl_rsp_t tbl_rsp;
    nvp_pkg::nvp_arr_cmd_t arr_cmd, lc;
    int err_total = 0, total_checks = 0, s0;
    nvp_ctrl #(.WRITE_CYCLES(8)) nvp_ctrl_i (.pclk, .presetn, .master_clear_pin_rst,
        .watchdog_timer_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .tbl_req, .tbl_rsp, .arr_rd_addr, .arr_rd_data, .arr_cmd, .arr_latch_idx,
        .arr_latch_data, .cpu_stall, .nvm_done_flag);
    nvp_array_model nvp_array_model_i (.pclk, .presetn, .arr_rd_addr, .arr_rd_data, .arr_cmd,
        .arr_latch_idx, .arr_latch_data);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic keys(input logic [31:0] k1, input logic [31:0] k2, input logic [31:0] c);
        apb(1'b1, A_KEY, k1);
        apb(1'b1, A_KEY, k2);
        apb(1'b1, A_CTL, c);
        repeat (2) @(posedge pclk);
    endtask : keys
    task automatic tbl(input nvp_pkg::nvp_tbl_op_t o, input logic [23:0] a, input logic [15:0] d);
        @(posedge pclk);
        tbl_req <= '{o, a, d};
        @(posedge pclk);
        tbl_req.op <= nvp_pkg::TBL_NONE;
        #1;
    endtask : tbl
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        #2000000;
        err_total++;
        finish_test();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_CTL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 16'h0100, 32'h0);
        chk(32'(er), 32'h1);
        for (int i = 0; i < 32; i++) begin
            tbl(nvp_pkg::TBL_WRITE_LOW, 24'h006000 + 24'(2 * i), 16'h1000 + 16'(i));
            tbl(nvp_pkg::TBL_WRITE_HIGH, 24'h006000 + 24'(2 * i), 16'hAB00 + 16'(i));
        end
        repeat (34) @(posedge pclk);
        for (int i = 0; i < 32; i++) begin
            chk(32'(nvp_array_model_i.img[i]), {8'h00, 8'(i), 16'h1000 + 16'(i)});
        end
        s0 = nvp_array_model_i.starts;
        apb(1'b1, A_CTL, 32'h4001);
        apb(1'b1, A_CTL, 32'hC001);
        apb(1'b1, A_CTL, 32'h0001);
        keys(32'h55, 32'hAA, 32'hC101);
        apb(1'b0, A_CTL, 32'h0);
        chk(rd, 32'h4101);
        apb(1'b1, A_KEY, 32'h55);
        keys(32'h55, 32'hAA, 32'hC001);
        apb(1'b1, A_KEY, 32'h55);
        apb(1'b0, A_STS, 32'h0);
        keys(32'hAA, 32'hAA, 32'hC001);
        keys(32'hAA, 32'h55, 32'hC001);
        chk(32'(nvp_array_model_i.starts - s0), 32'h1);
        while (nvm_done_flag !== 1'b1) @(posedge pclk);
        apb(1'b1, A_STS, 32'h1);
        foreach (ops[j]) begin
            op = ops[j];
            ad = op[2] ? 24'h7FFC26 : 24'h006046;
            msk = !op[2] ? nvp_pkg::ROW_MASK : op[0] ? nvp_pkg::EE_BLK_MASK : nvp_pkg::WORD_MASK;
            apb(1'b1, A_ADH, {24'h0, ad[23:16]});
            apb(1'b1, A_ADL, {16'h0, ad[15:0]});
            apb(1'b1, A_CTL, 32'h4000 | 32'(op));
            keys(32'h55, 32'hAA, 32'hC000 | 32'(op));
            tbl(nvp_pkg::TBL_READ_LOW, 24'h7FFC02, 16'h0);
            chk(32'({tbl_rsp.valid, tbl_rsp.rdata}),
                {15'h0000, 1'b1, op[2] ? 16'hFFFF : 16'hA658});
            chk(32'(cpu_stall), 32'(!op[2]));
            apb(1'b1, A_CTL, 32'(op));
            while (nvm_done_flag !== 1'b1) @(posedge pclk);
            lc = nvp_array_model_i.last_cmd;
            chk(32'({lc.erase, lc.eeprom, lc.multi, lc.addr}),
                {5'h00, op[6], op[2], op[0], ad & msk});
            chk(32'(cpu_stall), 32'h0);
            apb(1'b0, A_CTL, 32'h0);
            chk(rd, 32'(op));
            apb(1'b0, A_STS, 32'h0);
            chk(rd, 32'h1);
            apb(1'b1, A_STS, 32'h1);
            apb(1'b0, A_STS, 32'h0);
            chk(rd, 32'h0);
        end
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, A_ADL, 32'h6040);
            apb(1'b1, A_CTL, 32'h4041);
            keys(32'h55, 32'hAA, 32'hC041);
            @(posedge pclk);
            master_clear_pin_rst <= (k == 0);
            watchdog_timer_rst <= (k == 1);
            @(posedge pclk);
            master_clear_pin_rst <= 1'b0;
            watchdog_timer_rst <= 1'b0;
            apb(1'b0, A_CTL, 32'h0);
            chk(rd, 32'h2000);
            apb(1'b0, A_ADL, 32'h0);
            chk(rd, 32'h6040);
            apb(1'b1, A_CTL, 32'h0);
        end
        finish_test();
    end
endmodule : nvp_ctrl_tb
`default_nettype wire
